// ---- hdl/sirq_device.sv ----
/*
 device end of the serial interrupt link: tracks cycles, drives its slots, measures stop width.
 assumes the wire and clock are shared with the host and the line is sampled synchronously.
*/
// Behaviour
// - quiet start: one low clock, then release
// - no start while a cycle is active
// - host extends start low to 4-8 clocks
// - host drives high one clock, then releases
// - source change in quiet mode requests start
// - continuous mode: only host starts cycles
// - mode changes only at stop; reset continuous
// - device measures every stop width
// - count 3-clock frames from start rising edge
// - sample phase low only if source low
// - always release during turn-around
// - slot driven regardless of start initiator
// - slot n sampled 3n clocks after start
// - smi enables: bit 6 serial, bit 7 pin
// - slot 14 carries irq13
// - host stop: 2 clocks quiet, 3 continuous
// - quiet start allowed 2 clocks after stop
// - host supports at least 17 frames
// - all driving and sampling on rising edges
// - tri-state in reset, come up continuous idle
// - host runs first cycle after reset
// - host set continuous before reconfiguration
`default_nettype none
module sirq_device
   import sirq_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   // interrupt sources, index 0 is the unused slot, index 13 is irq13
   input  wire logic [SLOTS-1:0]     irq_level,
   input  wire logic                 sys_mgmt_request_n,
   input  wire logic [7:0]           smi_enable2,
   // dedicated management pin and status
   output logic                      sys_mgmt_interrupt_n,
   output logic                      quiet_mode,
   // link
   sirq_if.device                    link
);
   import sirq_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_DATA  = 5'h04,
      ST_STOP  = 5'h08,
      ST_GAP   = 5'h10
   } state_e;

   typedef struct packed {
      state_e           state;
      logic             quiet;
      logic             prev_line;
      logic [4:0]       slot;
      logic [1:0]       phase;
      logic [3:0]       low_cnt;
      logic [1:0]       gap;
      logic [SLOTS-1:0] last;
      logic [SLOTS-1:0] sent;
      logic             pend;
      logic             drove_low;
      logic             out;
      logic             oe;
      logic             smi_pin;
   } st_s;

   st_s r;
   st_s n;
   logic [SLOTS-1:0] src;

   ////////////////////////////////////////////////////////////////////////
   // source vector: slot 3 carries management request when enabled
   always_comb begin
      src = irq_level;
      if (smi_enable2[SER_SMI_BIT]) begin
         src[SMI_SLOT] = irq_level[SMI_SLOT] && sys_mgmt_request_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      n.prev_line = link.line;
      n.out = 1'b1;
      n.oe = 1'b0;
      // last holds the level seen one clock ago, so any edge shows up as a change against it
      n.last = src;
      n.smi_pin = !(smi_enable2[PIN_SMI_BIT] && !sys_mgmt_request_n);
      // a change not yet carried by this cycle's slots raises a request
      if (src != r.last) begin
         n.pend = 1'b1;
      end
      case (r.state)
         ST_IDLE: begin
            // a host start seen first is joined; a pending request rides that cycle
            if (!link.line) begin
               n.state = ST_START;
               n.low_cnt = 4'h1;
            end else if (r.quiet && r.pend) begin
               n.out = 1'b0;
               n.oe = 1'b1;
               n.state = ST_START;
               n.low_cnt = 4'h0;
            end
         end
         ST_START: begin
            // released after one clock, never driven high
            if (link.line && !r.prev_line) begin
               n.state = ST_DATA;
               n.slot = 5'h0;
               n.phase = PH_RECOVER;
               n.pend = (src != r.last);
               n.sent = '0;
            end
         end
         ST_DATA: begin
            // the start rising edge counts as clock 0, so sample of slot n lands 3n later
            case (r.phase)
               PH_SAMPLE: begin
                  n.phase = PH_RECOVER;
                  // restore high only after our own low, never fight another agent
                  if (r.drove_low) begin
                     n.out = 1'b1;
                     n.oe = 1'b1;
                  end
                  n.drove_low = 1'b0;
               end
               PH_RECOVER: begin
                  n.phase = PH_TURN;
               end
               default: begin
                  n.phase = PH_SAMPLE;
                  if (r.slot == 5'(SLOTS)) begin
                     n.state = ST_STOP;
                     n.low_cnt = 4'h0;
                  end else begin
                     n.slot = r.slot + 5'h1;
                     n.sent[r.slot[3:0]] = 1'b1;
                     if (r.slot != 5'h0 && !src[r.slot[3:0]]) begin
                        n.out = 1'b0;
                        n.oe = 1'b1;
                        n.drove_low = 1'b1;
                     end
                  end
               end
            endcase
            // a change on a slot still ahead rides this cycle; otherwise it waits
            if (src != r.last && (((src ^ r.last) & r.sent) == '0)) begin
               n.pend = r.pend;
            end
            // host may send more frames: wait for the next low, of any length, and take it as the stop
            // our own low in the last slot is not a stop
            if (r.slot == 5'(SLOTS) && !link.line && !r.drove_low) begin
               n.state = ST_STOP;
               n.low_cnt = 4'h1;
            end
         end
         ST_STOP: begin
            if (!link.line) begin
               n.low_cnt = r.low_cnt + 4'h1;
            // a low run is taken as quiet when low_cnt[2:0] is two (2, 10, 18 or any 8m+2 clocks, as low_cnt wraps), any other but a multiple of 16 as continuous
            end else if (r.low_cnt != 4'h0) begin
               n.quiet = (r.low_cnt[2:0] == STOP_QUIET);
               n.state = ST_GAP;
               n.gap = 2'h1;
            end
         end
         default: begin
            // start allowed from the second clock after the stop rising edge
            if (!link.line) begin
               n.state = ST_START;
               n.low_cnt = 4'h1;
            end else if (r.gap == IDLE_GAP - 2'h1) begin
               n.state = ST_IDLE;
            end else begin
               n.gap = r.gap + 2'h1;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state and outputs in one register; clk_en low freezes all of it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: ST_IDLE, quiet: 1'b0, prev_line: 1'b1, slot: 5'h0, phase: PH_SAMPLE,
               low_cnt: 4'h0, gap: 2'h0, last: '1, sent: '0, pend: 1'b0, drove_low: 1'b0,
               out: 1'b1, oe: 1'b0, smi_pin: 1'b1};
      end else if (clk_en) begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs come straight from flip-flops, so the wire sees no glitch
   assign link.dev_out = r.out;
   assign link.dev_oe = r.oe;
   assign sys_mgmt_interrupt_n = r.smi_pin;
   assign quiet_mode = r.quiet;
endmodule
`default_nettype wire

// ---- hdl/sirq_pkg.sv ----
/*
 shared constants for the serial interrupt link: frame timing, slot layout, stop widths.
 assumes one clock shared by both ends; the wire level is resolved in the interface.
*/
`default_nettype none
package sirq_pkg;
   localparam int          SLOTS          = 16;
   localparam int          FRAME_CLKS     = 3;
   localparam logic [1:0]  PH_SAMPLE      = 2'h0;
   localparam logic [1:0]  PH_RECOVER     = 2'h1;
   localparam logic [1:0]  PH_TURN        = 2'h2;
   localparam logic [3:0]  START_LOW_DEF  = 4'h4;   // host total start low, 4..8
   localparam logic [3:0]  START_LOW_MIN  = 4'h4;
   localparam logic [3:0]  START_LOW_MAX  = 4'h8;
   localparam logic [2:0]  STOP_QUIET     = 3'h2;
   localparam logic [2:0]  STOP_CONT      = 3'h3;
   localparam logic [5:0]  DATA_FRAMES    = 6'h11;  // host runs 17 frames
   localparam logic [1:0]  IDLE_GAP       = 2'h2;   // start allowed 2nd clock after stop rise
   localparam int          SMI_SLOT       = 2;      // zero-based index of period 3
   localparam int          SER_SMI_BIT    = 6;
   localparam int          PIN_SMI_BIT    = 7;
endpackage
`default_nettype wire

// ---- hdl/sirq_if.sv ----
/*
 the shared serial interrupt wire between host controller and device agent.
 assumes open-drain style wire with pull-up: resolves level from both drivers' enables.
*/
`default_nettype none
interface sirq_if;
   logic host_out;
   logic host_oe;
   logic dev_out;
   logic dev_oe;
   logic line;
   // pull-up when nobody drives; a low from either end wins
   assign line = (host_oe && !host_out) || (dev_oe && !dev_out) ? 1'b0 : 1'b1;
   modport host (output host_out, output host_oe, input line);
   modport device (output dev_out, output dev_oe, input line);
endinterface
`default_nettype wire

// ---- hdl/sirq_host.sv ----
/*
 host controller end: runs start, 17 data frames and stop, collects slot levels.
 assumes the device end shares clock and wire; mode and start width come from user ports.
*/
`default_nettype none
module sirq_host
   import sirq_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   // control
   input  wire logic                 run,
   input  wire logic                 want_quiet,
   input  wire logic [3:0]           start_low,
   // results
   output logic [SLOTS-1:0]          slot_level,
   output logic                      cycle_done,
   output logic                      busy,
   // link
   sirq_if.host                      link
);
   import sirq_pkg::*;

   typedef enum logic [4:0] {
      H_IDLE  = 5'h01,
      H_START = 5'h02,
      H_HIGH  = 5'h04,
      H_DATA  = 5'h08,
      H_STOP  = 5'h10
   } state_e;

   typedef struct packed {
      state_e           state;
      logic             quiet;
      logic             first;
      logic [3:0]       cnt;
      logic [5:0]       frame;
      logic [1:0]       phase;
      logic [SLOTS-1:0] level;
      logic             done;
      logic             out;
      logic             oe;
   } st_s;

   st_s r;
   st_s n;
   logic [3:0] width;

   // out-of-range start widths are clamped into 4..8
   assign width = (start_low < START_LOW_MIN) ? START_LOW_MIN :
                  (start_low > START_LOW_MAX) ? START_LOW_MAX : start_low;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      n.out = 1'b1;
      n.oe = 1'b0;
      n.done = 1'b0;
      case (r.state)
         H_IDLE: begin
            // stay off the wire for the released clock after the stop's high
            if (!r.done && (r.first || run || (r.quiet && !link.line))) begin
               n.state = H_START;
               n.first = 1'b0;
               n.out = 1'b0;
               n.oe = 1'b1;
               n.cnt = (r.quiet && !link.line) ? 4'h2 : 4'h1;
            end
         end
         H_START: begin
            if (r.cnt >= width) begin
               n.state = H_HIGH;
               n.out = 1'b1;
               n.oe = 1'b1;
            end else begin
               n.out = 1'b0;
               n.oe = 1'b1;
               n.cnt = r.cnt + 4'h1;
            end
         end
         H_HIGH: begin
            n.state = H_DATA;
            // wraps to 0 at the first turn-around, so frame k samples slot k
            n.frame = '1;
            n.phase = PH_RECOVER;
         end
         H_DATA: begin
            case (r.phase)
               PH_SAMPLE: begin
                  if (r.frame < 6'(SLOTS)) begin
                     n.level[r.frame[3:0]] = link.line;
                  end
                  n.phase = PH_RECOVER;
               end
               PH_RECOVER: n.phase = PH_TURN;
               default: begin
                  n.phase = PH_SAMPLE;
                  n.frame = r.frame + 6'h1;
                  if (r.frame + 6'h1 == DATA_FRAMES) begin
                     n.state = H_STOP;
                     n.quiet = want_quiet;
                     n.cnt = 4'h1;
                     n.out = 1'b0;
                     n.oe = 1'b1;
                  end
               end
            endcase
         end
         default: begin
            if (r.cnt < (r.quiet ? 4'(STOP_QUIET) : 4'(STOP_CONT))) begin
               n.cnt = r.cnt + 4'h1;
               n.out = 1'b0;
               n.oe = 1'b1;
            end else begin
               n.state = H_IDLE;
               n.out = 1'b1;
               n.oe = 1'b1;
               n.done = 1'b1;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: H_IDLE, quiet: 1'b0, first: 1'b1, cnt: 4'h0, frame: 6'h0, phase: PH_SAMPLE,
               level: '1, done: 1'b0, out: 1'b1, oe: 1'b0};
      end else if (clk_en) begin
         r <= n;
      end
   end

   assign link.host_out = r.out;
   assign link.host_oe = r.oe;
   assign slot_level = r.level;
   assign cycle_done = r.done;
   assign busy = (r.state != H_IDLE);
endmodule
`default_nettype wire

// ---- tb/sirq_chk.sv ----
/*
 assertions on the shared serial interrupt wire.
 assumes one clock; fed from the interface signals by the bench.
*/
`default_nettype none
module sirq_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // drivers and resolved wire
   input wire logic host_out,
   input wire logic host_oe,
   input wire logic dev_out,
   input wire logic dev_oe,
   input wire logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lo_cnt;
   logic [7:0] pos;
   logic [7:0] gap;
   logic       quiet;
   logic       dev_lo;
   logic       host_lo;
   logic       stop_rise;
   assign dev_lo = dev_oe && !dev_out;
   assign host_lo = host_oe && !host_out;
   // slot lows last one clock, so only a stop gives 2 or 3 low late in a cycle
   assign stop_rise = line && (lo_cnt == 8'h02 || lo_cnt == 8'h03) && pos > 8'h32;
   ////////////////////////////////////////////////////////////////
   // wire history: low run, clocks since start rise, clocks since stop rise
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt <= 8'h00;
         pos <= 8'hff;
         gap <= 8'hff;
         quiet <= 1'b0;
      end else begin
         lo_cnt <= line ? 8'h00 : lo_cnt + 8'h01;
         pos <= (line && lo_cnt > 8'h03) ? 8'h01 : pos + 8'(pos != 8'hff);
         gap <= stop_rise ? 8'h01 : gap + 8'(gap != 8'hff);
         if (stop_rise) begin
            quiet <= (lo_cnt == 8'h02);
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence host_low_end;
      host_lo ##1 !host_lo;
   endsequence
   a_reset_tri_state: assert property ($rose(rst_n) |-> !host_oe && !dev_oe)
      else $error("driver enabled out of reset");
   a_dev_low_single: assert property (dev_lo |=> !dev_lo)
      else $error("device low longer than one clock");
   a_dev_high_recov: assert property (dev_oe && dev_out |-> $past(dev_lo))
      else $error("device high without own low");
   a_dev_turn_release: assert property (dev_oe && dev_out |=> !dev_oe)
      else $error("device drives in turn-around");
   a_slot_phase: assert property (dev_lo && pos < 8'h33 |-> pos % 8'h03 == 8'h00)
      else $error("device low outside sample phase");
   a_start_release: assert property (dev_lo && pos > 8'h32 |=> !dev_oe)
      else $error("device start not released");
   a_start_mode_gap: assert property (dev_lo && pos > 8'h32 |-> quiet && gap > 8'h01 && gap < pos)
      else $error("device start in wrong mode or gap");
   a_host_high_release: assert property (host_low_end |-> host_oe && host_out ##1 !host_oe)
      else $error("host low not ended by one high clock");
   a_host_frames_min: assert property ($rose(host_lo) && pos < 8'hff |-> pos > 8'h35)
      else $error("host low before seventeen frames ended");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 bench for host and device ends joined on one wire.
 assumes both ends share the clock; clock enables held high, so stall paths go untested.
*/
`default_nettype none
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin failures++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, g, w); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sirq_pkg::*;
   logic clk_sys, rst_n, run, want_quiet, cycle_done, busy;
   logic sys_mgmt_request_n, sys_mgmt_interrupt_n, quiet_mode;
   logic [3:0] start_low;
   logic [7:0] smi_enable2;
   logic [SLOTS-1:0] irq_level, slot_level, exp;
   int failures, checks, k, n;
   sirq_if sirq_if_inst ();
   sirq_host sirq_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .run(run),
      .want_quiet(want_quiet), .start_low(start_low), .slot_level(slot_level),
      .cycle_done(cycle_done), .busy(busy), .link(sirq_if_inst.host));
   sirq_device sirq_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
      .irq_level(irq_level), .sys_mgmt_request_n(sys_mgmt_request_n), .smi_enable2(smi_enable2),
      .sys_mgmt_interrupt_n(sys_mgmt_interrupt_n), .quiet_mode(quiet_mode), .link(sirq_if_inst.device));
   sirq_chk sirq_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .host_out(sirq_if_inst.host_out),
      .host_oe(sirq_if_inst.host_oe), .dev_out(sirq_if_inst.dev_out), .dev_oe(sirq_if_inst.dev_oe),
      .line(sirq_if_inst.line));
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wait_done();
      int i;
      i = 0;
      do begin
         @(posedge clk_sys);
         #1;
         i++;
      end while (cycle_done !== 1'b1 && i < 300);
      if (cycle_done !== 1'b1) begin
         failures++;
         end_of_test();
      end
   endtask
   // two cycles: the first may have sampled old levels already
   task automatic slot_case(input logic [SLOTS-1:0] lv, input logic [7:0] en, input logic rq,
                            input logic [3:0] sl);
      @(posedge clk_sys);
      irq_level <= lv;
      smi_enable2 <= en;
      sys_mgmt_request_n <= rq;
      start_low <= sl;
      wait_done();
      wait_done();
      exp = lv;
      exp[SMI_SLOT] = lv[SMI_SLOT] & ~(en[SER_SMI_BIT] & ~rq);
      // slot 0 is unused and never driven
      exp[0] = 1'b1;
      `CHK(slot_level, exp)
      `CHK(sys_mgmt_interrupt_n, ~(en[PIN_SMI_BIT] & ~rq))
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      rst_n = 1'b0;
      run = 1'b0;
      want_quiet = 1'b0;
      start_low = START_LOW_DEF;
      irq_level = 16'hffff;
      sys_mgmt_request_n = 1'b1;
      smi_enable2 = 8'h00;
      failures = 0;
      checks = 0;
      repeat (20) @(posedge clk_sys);
      `CHK({sirq_if_inst.host_oe, sirq_if_inst.dev_oe}, 2'h0)
      `CHK(quiet_mode, 1'b0)
      rst_n <= 1'b1;
      wait_done();
      `CHK(slot_level, 16'hffff)
      @(posedge clk_sys);
      run <= 1'b1;
      for (k = 0; k < SLOTS; k++) begin
         slot_case(~(16'h0001 << k), 8'h00, 1'b1, 4'(4 + k % 5));
      end
      for (k = 0; k < 4; k++) begin
         slot_case(16'hffff, 8'(k << 6), 1'b0, START_LOW_MAX);
      end
      @(posedge clk_sys);
      want_quiet <= 1'b1;
      sys_mgmt_request_n <= 1'b1;
      wait_done();
      wait_done();
      @(posedge clk_sys);
      run <= 1'b0;
      // lets a cycle already begun run out
      repeat (100) @(posedge clk_sys);
      #1;
      `CHK(quiet_mode, 1'b1)
      `CHK(busy, 1'b0)
      @(posedge clk_sys);
      irq_level <= 16'hffdf;
      want_quiet <= 1'b0;
      wait_done();
      @(posedge clk_sys);
      #1;
      `CHK(slot_level, 16'hffdf)
      `CHK(quiet_mode, 1'b0)
      @(posedge clk_sys);
      irq_level <= 16'hffff;
      n = 0;
      repeat (200) begin
         @(posedge clk_sys);
         #1;
         n += int'(cycle_done === 1'b1);
      end
      `CHK(n, 0)
      end_of_test();
   end
endmodule
`default_nettype wire
